// file: hw/sbst_pkg.sv
// Constants for the memory boundary-scan test access port
package sbst_pkg;
   localparam int IR_WIDTH = 3;
   localparam int ID_WIDTH = 32;
   localparam int BSR_WIDTH = 107;
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLEZ = 3'h2;
   localparam logic [2:0] INS_PRELOAD = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   localparam int OE_CELL = 47;
   // Identity fields; values are arbitrary except ID_PRESENT, which the identity checks require to be one
   localparam logic [2:0] ID_VERSION = 3'h1;
   localparam logic [16:0] ID_PART = 17'h00123;
   localparam logic [10:0] ID_MAKER = 11'h055;
   localparam logic ID_PRESENT = 1'h1;
   typedef enum logic [3:0] {
      S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR, S_EX2_DR, S_UPD_DR,
      S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PAU_IR, S_EX2_IR, S_UPD_IR
   } sbst_state_t;
endpackage

// file: hw/sbst_tap.sv
// Boundary-scan test access port, sampled on the system clock
`timescale 1ns/1ps
module sbst_tap #(
   parameter int BSR_W = sbst_pkg::BSR_WIDTH
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             tck,
   input  wire logic             tms,
   input  wire logic             tdi,
   output logic                  tdo,
   output logic                  tdo_oe_n,
   input  wire logic [BSR_W-1:0] pin_ring,
   output logic      [BSR_W-1:0] pin_drive,
   output logic                  extest_mode,
   output logic                  mem_out_en,
   output logic      [2:0]       current_ins
);
   logic [2:0] tck_s;
   logic       tms_m, tms_s, tdi_m, tdi_s;
   sbst_pkg::sbst_state_t state, next_state;
   logic [2:0]       ir_shift;
   logic [31:0]      id_shift;
   logic             bypass_bit;
   logic [BSR_W-1:0] bsr_shift;
   logic [BSR_W-1:0] bsr_latch;

   // Reserved codes fall back to the bypass path
   function automatic logic routes_to_bypass(input logic [2:0] code);
      logic hit;
      hit = 1'h0;
      case (code)
         sbst_pkg::INS_BYPASS: hit = 1'h1;
         3'h3:                 hit = 1'h1;
         3'h5:                 hit = 1'h1;
         3'h6:                 hit = 1'h1;
         default:              hit = 1'h0;
      endcase
      return hit;
   endfunction

   // Idle test clock is low; no false edge after reset
   always_ff @(posedge clock) begin
      if (rst) begin
         tck_s <= 3'h0;
      end else begin
         tck_s <= {tck_s[1:0], tck};
      end
   end

   always_ff @(posedge clock) begin
      tms_m <= tms;
      tms_s <= tms_m;
      tdi_m <= tdi;
      tdi_s <= tdi_m;
   end

   wire rise = tck_s[1] & ~tck_s[2];
   wire fall = ~tck_s[1] & tck_s[2];
   wire [31:0] id_value = {sbst_pkg::ID_VERSION, sbst_pkg::ID_PART,
                           sbst_pkg::ID_MAKER, sbst_pkg::ID_PRESENT};
   wire sel_id  = current_ins == sbst_pkg::INS_IDCODE;
   wire sel_byp = routes_to_bypass(current_ins);
   wire sel_bsr = ~sel_id & ~sel_byp;
   wire in_ir   = state == sbst_pkg::S_SH_IR;
   wire in_dr   = state == sbst_pkg::S_SH_DR;
   wire serial_bit = in_ir ? ir_shift[0] : sel_id ? id_shift[0] :
                     sel_byp ? bypass_bit : bsr_shift[0];

   always_comb begin
      case (state)
         sbst_pkg::S_RESET:   next_state = tms_s ? sbst_pkg::S_RESET  : sbst_pkg::S_IDLE;
         sbst_pkg::S_IDLE:    next_state = tms_s ? sbst_pkg::S_SEL_DR : sbst_pkg::S_IDLE;
         sbst_pkg::S_SEL_DR:  next_state = tms_s ? sbst_pkg::S_SEL_IR : sbst_pkg::S_CAP_DR;
         sbst_pkg::S_CAP_DR:  next_state = tms_s ? sbst_pkg::S_EX1_DR : sbst_pkg::S_SH_DR;
         sbst_pkg::S_SH_DR:   next_state = tms_s ? sbst_pkg::S_EX1_DR : sbst_pkg::S_SH_DR;
         sbst_pkg::S_EX1_DR:  next_state = tms_s ? sbst_pkg::S_UPD_DR : sbst_pkg::S_PAU_DR;
         sbst_pkg::S_PAU_DR:  next_state = tms_s ? sbst_pkg::S_EX2_DR : sbst_pkg::S_PAU_DR;
         sbst_pkg::S_EX2_DR:  next_state = tms_s ? sbst_pkg::S_UPD_DR : sbst_pkg::S_SH_DR;
         sbst_pkg::S_UPD_DR:  next_state = tms_s ? sbst_pkg::S_SEL_DR : sbst_pkg::S_IDLE;
         sbst_pkg::S_SEL_IR:  next_state = tms_s ? sbst_pkg::S_RESET  : sbst_pkg::S_CAP_IR;
         sbst_pkg::S_CAP_IR:  next_state = tms_s ? sbst_pkg::S_EX1_IR : sbst_pkg::S_SH_IR;
         sbst_pkg::S_SH_IR:   next_state = tms_s ? sbst_pkg::S_EX1_IR : sbst_pkg::S_SH_IR;
         sbst_pkg::S_EX1_IR:  next_state = tms_s ? sbst_pkg::S_UPD_IR : sbst_pkg::S_PAU_IR;
         sbst_pkg::S_PAU_IR:  next_state = tms_s ? sbst_pkg::S_EX2_IR : sbst_pkg::S_PAU_IR;
         sbst_pkg::S_EX2_IR:  next_state = tms_s ? sbst_pkg::S_UPD_IR : sbst_pkg::S_SH_IR;
         sbst_pkg::S_UPD_IR:  next_state = tms_s ? sbst_pkg::S_SEL_DR : sbst_pkg::S_IDLE;
         default:             next_state = sbst_pkg::S_RESET;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= sbst_pkg::S_RESET;
      end else if (rise) begin
         state <= next_state;
      end
   end

   // Instruction path
   always_ff @(posedge clock) begin
      if (rst || state == sbst_pkg::S_RESET) begin
         current_ins <= sbst_pkg::INS_IDCODE;
         ir_shift    <= sbst_pkg::INS_IDCODE;
      end else if (rise) begin
         if (state == sbst_pkg::S_CAP_IR) begin
            ir_shift <= {1'h0, sbst_pkg::IR_CAPTURE};
         end else if (in_ir) begin
            ir_shift <= {tdi_s, ir_shift[2:1]};
         end else if (state == sbst_pkg::S_UPD_IR) begin
            current_ins <= ir_shift;
         end
      end
   end

   // Data registers
   always_ff @(posedge clock) begin
      if (rst) begin
         id_shift   <= 32'h0;
         bypass_bit <= 1'h0;
         bsr_shift  <= '0;
      end else if (rise && state == sbst_pkg::S_CAP_DR) begin
         id_shift   <= id_value;
         bypass_bit <= 1'h0;
         bsr_shift  <= pin_ring;
      end else if (rise && in_dr) begin
         if (sel_id) id_shift <= {tdi_s, id_shift[31:1]};
         if (sel_byp) bypass_bit <= tdi_s;
         if (sel_bsr) bsr_shift <= {tdi_s, bsr_shift[BSR_W-1:1]};
      end
   end

   always_ff @(posedge clock) begin
      if (rst || state == sbst_pkg::S_RESET) begin
         bsr_latch <= '0;
         bsr_latch[sbst_pkg::OE_CELL] <= 1'h1;
      end else if (rise && state == sbst_pkg::S_UPD_DR && sel_bsr) begin
         bsr_latch <= bsr_shift;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tdo      <= 1'h0;
         tdo_oe_n <= 1'h1;
      end else if (fall) begin
         tdo      <= serial_bit;
         tdo_oe_n <= ~(in_ir | in_dr);
      end
   end

   assign extest_mode = current_ins == sbst_pkg::INS_EXTEST;
   assign pin_drive   = bsr_latch;
   assign mem_out_en  = current_ins == sbst_pkg::INS_SAMPLEZ ? 1'h0 :
                        extest_mode ? bsr_latch[sbst_pkg::OE_CELL] : 1'h1;

   chk_ins_reset: assert property (@(posedge clock) disable iff (rst)
      state == sbst_pkg::S_RESET |=> current_ins == sbst_pkg::INS_IDCODE)
      else $error("instruction not identification after test reset");
   chk_five_ones: assert property (@(posedge clock) disable iff (rst)
      rise && tms_s && state == sbst_pkg::S_SEL_IR |=> state == sbst_pkg::S_RESET)
      else $error("select-IR with TMS high did not reach reset");
   chk_ir_capture: assert property (@(posedge clock) disable iff (rst)
      rise && state == sbst_pkg::S_CAP_IR |=> ir_shift[1:0] == sbst_pkg::IR_CAPTURE)
      else $error("capture-IR pattern wrong");
   chk_id_capture: assert property (@(posedge clock) disable iff (rst)
      rise && state == sbst_pkg::S_CAP_DR && sel_id |=> id_shift[0] == 1'h1)
      else $error("identity lsb not one after capture");
   chk_samplez_float: assert property (@(posedge clock) disable iff (rst)
      current_ins == sbst_pkg::INS_SAMPLEZ |-> !mem_out_en)
      else $error("outputs driven under sample-z");
   chk_preload_keep: assert property (@(posedge clock) disable iff (rst)
      current_ins == sbst_pkg::INS_PRELOAD |-> mem_out_en && !extest_mode)
      else $error("preload disturbed memory outputs");
   chk_bypass_path: assert property (@(posedge clock) disable iff (rst)
      fall && in_dr && current_ins == sbst_pkg::INS_BYPASS |=> tdo == $past(bypass_bit))
      else $error("bypass bit not on serial output");
   chk_tdo_fall: assert property (@(posedge clock) disable iff (rst)
      !fall |=> $stable(tdo))
      else $error("serial output changed off falling edge");
   chk_oe_cell: assert property (@(posedge clock) disable iff (rst)
      extest_mode |-> mem_out_en == bsr_latch[sbst_pkg::OE_CELL])
      else $error("extest output gate not from cell");
   chk_upd_ir: assert property (@(posedge clock) disable iff (rst)
      rise && state == sbst_pkg::S_UPD_IR |=> current_ins == $past(ir_shift))
      else $error("instruction not applied at update-IR");

   sequence s_dr_capture;
      rise && state == sbst_pkg::S_CAP_DR;
   endsequence
   sequence s_ir_shift;
      rise && in_ir;
   endsequence
   sequence s_dr_update;
      rise && state == sbst_pkg::S_UPD_DR && sel_bsr;
   endsequence

   chk_state_hold: assert property (@(posedge clock) disable iff (rst)
      !rise |=> $stable(state))
      else $error("test state moved without a test clock rise");
   chk_ir_shift: assert property (@(posedge clock) disable iff (rst)
      s_ir_shift |=> ir_shift[2] == $past(tdi_s))
      else $error("instruction shift did not take serial input");
   chk_byp_capture: assert property (@(posedge clock) disable iff (rst)
      s_dr_capture |=> !bypass_bit)
      else $error("bypass bit not cleared at capture");
   chk_dr_update: assert property (@(posedge clock) disable iff (rst)
      s_dr_update |=> pin_drive == $past(bsr_shift))
      else $error("scan chain not latched at update");
   chk_tlr_cell: assert property (@(posedge clock) disable iff (rst)
      state == sbst_pkg::S_RESET |=> pin_drive[sbst_pkg::OE_CELL])
      else $error("output gate cell not preset in test reset");
   chk_oe_shift: assert property (@(posedge clock) disable iff (rst)
      fall && (in_ir || in_dr) |=> !tdo_oe_n)
      else $error("serial output not enabled during shift");
endmodule

// file: test/sbst_ctrl.sv
// Board-side boundary-scan controller model
`timescale 1ns/1ps
module sbst_ctrl (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One test clock; levels set half a period before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #24 tck = 1'b1;
      q = tdo;
      #24 tck = 1'b0;
   endtask
   task automatic walk(input logic [3:0] path, input int n);
      logic q;
      for (int i = 0; i < n; i++) begin
         step(path[i], tdi, q);
      end
   endtask
   // Shift LSB first, then update and idle
   task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
      logic q;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      walk(4'h1, 2);
   endtask
   task automatic dr(input int n, input logic [127:0] din, output logic [127:0] dout);
      walk(4'h1, 3);
      scan(n, din, dout);
   endtask
   // Only defined codes are ever loaded
   task automatic ir(input logic [2:0] code, output logic [127:0] cap);
      walk(4'h3, 4);
      scan(3, {125'h0, code}, cap);
   endtask
   task automatic tlr();
      walk(4'hf, 4);
      walk(4'h1, 2);
   endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the boundary-scan access port
`timescale 1ns/1ps
module tb_top;
   localparam logic [106:0] RING = {27'h5a5a5a5, 80'hc3c3_1234_5678_9abc_def0};
   localparam logic [106:0] PRE  = ~RING & ~(107'h1 << 47);
   logic         clock = 1'b0;
   logic         rst = 1'b1;
   logic [106:0] pin_ring = '0;
   logic         tck, tms, tdi, tdo, tdo_oe_n, extest_mode, mem_out_en;
   logic [106:0] pin_drive;
   logic [2:0]   current_ins;
   logic [127:0] got;
   int           mismatches = 0;
   int           checked = 0;
   int           cycles = 0;
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         summarize();
      end
   end
   logic         tdo_line;
   // Released serial line floats up to the pull-up level
   assign tdo_line = tdo_oe_n ? 1'b1 : tdo;
   sbst_ctrl ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
   sbst_tap dut (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .pin_ring(pin_ring), .pin_drive(pin_drive),
      .extest_mode(extest_mode), .mem_out_en(mem_out_en), .current_ins(current_ins));
   task automatic cmp(input logic [127:0] g, input logic [127:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic t_reset();
      cmp(current_ins, sbst_pkg::INS_IDCODE);
      cmp(pin_drive[47], 1'b1);
      cmp({tdo_oe_n, mem_out_en}, 2'h3);
      ctrl.tlr();
      cmp(current_ins, sbst_pkg::INS_IDCODE);
   endtask
   task automatic t_idcode();
      ctrl.ir(sbst_pkg::INS_IDCODE, got);
      cmp(got, 128'h1);
      ctrl.dr(32, '0, got);
      cmp(got, {sbst_pkg::ID_VERSION, sbst_pkg::ID_PART, sbst_pkg::ID_MAKER, 1'b1});
   endtask
   task automatic t_bypass();
      ctrl.ir(sbst_pkg::INS_BYPASS, got);
      cmp(current_ins, sbst_pkg::INS_BYPASS);
      ctrl.dr(3, 128'h7, got);
      cmp(got, 128'h6);
      cmp(mem_out_en, 1'b1);
   endtask
   task automatic t_preload();
      @(posedge clock) #1 pin_ring = RING;
      ctrl.ir(sbst_pkg::INS_PRELOAD, got);
      ctrl.dr(107, PRE, got);
      cmp(got, RING);
      cmp(pin_drive, PRE);
      cmp({extest_mode, mem_out_en}, 2'h1);
   endtask
   task automatic t_extest();
      ctrl.ir(sbst_pkg::INS_EXTEST, got);
      cmp({extest_mode, mem_out_en}, 2'h2);
      ctrl.dr(107, PRE | (107'h1 << 47), got);
      cmp(got, RING);
      cmp(pin_drive, PRE | (107'h1 << 47));
      cmp(mem_out_en, 1'b1);
   endtask
   task automatic t_sys_reset();
      @(posedge clock) #1 rst = 1'b1;
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      cmp(current_ins, sbst_pkg::INS_IDCODE);
      cmp(pin_drive, 107'h1 << 47);
      cmp({extest_mode, mem_out_en, tdo_oe_n}, 3'h3);
      ctrl.tlr();
   endtask
   task automatic t_samplez();
      ctrl.ir(sbst_pkg::INS_SAMPLEZ, got);
      cmp(mem_out_en, 1'b0);
      ctrl.dr(107, '0, got);
      cmp(got, RING);
      cmp(pin_drive, 107'h0);
   endtask
   task automatic t_tlr();
      ctrl.tlr();
      cmp(current_ins, sbst_pkg::INS_IDCODE);
      cmp({pin_drive[47], mem_out_en}, 2'h3);
   endtask
   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      t_reset();
      t_idcode();
      t_bypass();
      t_preload();
      t_extest();
      t_sys_reset();
      t_samplez();
      t_tlr();
      summarize();
   end
endmodule
